//--- inc/ofs_pkg.sv
// Constants, object codes and state types of the output fault and scaling object bank
package ofs_pkg;

  // Object dictionary indices of the held objects
  localparam logic [15:0] IDX_SW_RESPONSE = 16'h6250;
  localparam logic [15:0] IDX_SW_LEVEL = 16'h6260;
  localparam logic [15:0] IDX_CI_DIGITS = 16'h6302;
  localparam logic [15:0] IDX_KIND = 16'h6310;
  localparam logic [15:0] IDX_DO_DIGITS = 16'h6332;
  localparam logic [15:0] IDX_AN_RESPONSE = 16'h6340;
  localparam logic [15:0] IDX_CI_VALUE = 16'h7300;
  localparam logic [15:0] IDX_LOWER_POINT = 16'h7320;
  localparam logic [15:0] IDX_AN_LEVEL = 16'h7341;

  // Sub-index layout of every per-output array
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_FIRST = 8'h01;
  localparam logic [7:0] SUB_LAST = 8'h02;
  localparam logic [15:0] SUB_MAX_VALUE = 16'h0002;

  // Reset values and value limits
  localparam logic [7:0] RST_RESPONSE = 8'h01;
  localparam logic RST_SW_LEVEL = 1'b1;
  localparam logic [7:0] RST_DIGITS = 8'h03;
  localparam logic [15:0] RST_KIND = 16'h000A;
  localparam logic [15:0] RST_CI_VALUE = 16'h0000;
  localparam logic [15:0] RST_LOWER_POINT = 16'h0000;
  localparam logic [15:0] RST_AN_LEVEL = 16'h0000;
  localparam logic [15:0] DIGITS_MAX = 16'h0004;
  localparam logic [15:0] LEVEL_MAX = 16'h0001;
  localparam logic [7:0] RESPONSE_APPLY = 8'h01;

  typedef enum logic [3:0] {
    OBJ_NONE,
    OBJ_SW_RESPONSE,
    OBJ_SW_LEVEL,
    OBJ_CI_DIGITS,
    OBJ_KIND,
    OBJ_DO_DIGITS,
    OBJ_AN_RESPONSE,
    OBJ_CI_VALUE,
    OBJ_LOWER_POINT,
    OBJ_AN_LEVEL
  } ofs_obj_t;

  // Stored objects of one output channel
  typedef struct packed {
    logic [7:0] switched_fault_response;
    logic switched_fault_level;
    logic [7:0] control_input_digits;
    logic [15:0] analog_channel_kind;
    logic [7:0] drive_output_digits;
    logic [7:0] analog_fault_response;
    logic [15:0] control_input_value;
    logic [15:0] lower_input_point;
    logic [15:0] analog_fault_level;
  } ofs_chan_state_t;

  localparam ofs_chan_state_t CHAN_RESET = '{
    switched_fault_response: RST_RESPONSE,
    switched_fault_level: RST_SW_LEVEL,
    control_input_digits: RST_DIGITS,
    analog_channel_kind: RST_KIND,
    drive_output_digits: RST_DIGITS,
    analog_fault_response: RST_RESPONSE,
    control_input_value: RST_CI_VALUE,
    lower_input_point: RST_LOWER_POINT,
    analog_fault_level: RST_AN_LEVEL
  };

  // Answer and output state of the bank
  typedef struct packed {
    logic obj_ack;
    logic obj_err;
    logic [15:0] obj_rdata;
    logic [1:0] switched_out;
    logic [1:0][15:0] analog_drive;
    logic [1:0][15:0] analog_fb_input;
  } ofs_bank_state_t;

  localparam ofs_bank_state_t BANK_RESET = '{
    obj_ack: 1'b0,
    obj_err: 1'b0,
    obj_rdata: 16'h0000,
    switched_out: 2'h0,
    analog_drive: 32'h0000_0000,
    analog_fb_input: 32'h0000_0000
  };

endpackage

//--- inc/ofs_chan_if.sv
// Write port and stored objects between the bank decoder and one channel store
`timescale 1ns/100ps
`default_nettype none
interface ofs_chan_if;
  logic wr_en;
  ofs_pkg::ofs_obj_t wr_obj;
  logic [15:0] wr_data;
  ofs_pkg::ofs_chan_state_t cfg;

  modport bank (output wr_en, output wr_obj, output wr_data, input cfg);
  modport store (input wr_en, input wr_obj, input wr_data, output cfg);
endinterface
`default_nettype wire

//--- core/ofs_channel.sv
// Object store of one output channel
`timescale 1ns/100ps
`default_nettype none
module ofs_channel (
  input wire logic clk_sys,
  input wire logic rst_n,
  ofs_chan_if.store port_if
);

  ofs_pkg::ofs_chan_state_t state_reg;
  ofs_pkg::ofs_chan_state_t state_next;

  ////////////////////////////////////////////////////////////////////////////
  // Writes arrive already checked, so the store only slices and keeps
  always_comb begin
    state_next = state_reg;
    if (port_if.wr_en) begin
      unique case (port_if.wr_obj)
        ofs_pkg::OBJ_NONE: begin
          state_next = state_reg;
        end
        ofs_pkg::OBJ_SW_RESPONSE: begin
          state_next.switched_fault_response = port_if.wr_data[7:0];
        end
        ofs_pkg::OBJ_SW_LEVEL: begin
          state_next.switched_fault_level = port_if.wr_data[0];
        end
        ofs_pkg::OBJ_CI_DIGITS: begin
          state_next.control_input_digits = port_if.wr_data[7:0];
        end
        ofs_pkg::OBJ_KIND: begin
          state_next.analog_channel_kind = port_if.wr_data;
        end
        ofs_pkg::OBJ_DO_DIGITS: begin
          state_next.drive_output_digits = port_if.wr_data[7:0];
        end
        ofs_pkg::OBJ_AN_RESPONSE: begin
          state_next.analog_fault_response = port_if.wr_data[7:0];
        end
        ofs_pkg::OBJ_CI_VALUE: begin
          state_next.control_input_value = port_if.wr_data;
        end
        ofs_pkg::OBJ_LOWER_POINT: begin
          state_next.lower_input_point = port_if.wr_data;
        end
        ofs_pkg::OBJ_AN_LEVEL: begin
          state_next.analog_fault_level = port_if.wr_data;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset values of every object
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ofs_pkg::CHAN_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign port_if.cfg = state_reg;

endmodule // ofs_channel
`default_nettype wire

//--- core/ofs_object_bank.sv
// Object bank for output fault responses, resolutions, kinds and input scaling
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Each digital output keeps a read-write fault response mode.
// - Digital fault response mode resets to 1, apply stored fault level.
// - On fault with response enabled, digital output takes its stored level.
// - Control input digit count per channel, 0 to 4, reset 3.
// - Drive output digit count per channel, 0 to 4, reset 3.
// - Sixteen-bit analog channel kind, read-write, reset 10 for voltage.
// - Analog fault response mode, read-write, reset 1, apply fault level.
// - Message-controlled channel feeds its signed control input value onward.
// - Lower input point uses control input digits, reset 0.
// - Sub-index zero is read-only and reads 2; entries at 1 and 2.
// - On fault with response enabled, analog output takes stored fault level.
module ofs_object_bank (
  input wire logic clk_sys,
  input wire logic rst_n,
  // Object access from the network stack
  input wire logic obj_req,
  input wire logic obj_wr,
  input wire logic [15:0] obj_index,
  input wire logic [7:0] obj_subindex,
  input wire logic [15:0] obj_wdata,
  output logic obj_ack,
  output logic obj_err,
  output logic [15:0] obj_rdata,
  // Digital output path
  input wire logic [1:0] switched_cmd,
  input wire logic [1:0] switched_fault_in,
  output logic [1:0] switched_out,
  // Analog output path
  input wire logic [1:0] analog_src_msg,
  input wire logic [1:0][15:0] analog_local_input,
  input wire logic [1:0][15:0] analog_scaled_value,
  input wire logic [1:0] analog_fault_in,
  output logic [1:0][15:0] analog_fb_input,
  output logic [1:0][15:0] analog_drive,
  // Configuration seen by the scaling function block
  output logic [1:0][7:0] control_input_digits,
  output logic [1:0][7:0] drive_output_digits,
  output logic [1:0][15:0] analog_channel_kind,
  output logic [1:0][15:0] lower_input_point
);

  ofs_pkg::ofs_bank_state_t state_reg;
  ofs_pkg::ofs_bank_state_t state_next;
  ofs_pkg::ofs_chan_state_t cfg [2];
  ofs_pkg::ofs_obj_t hit_obj;
  logic sub_count;
  logic sub_entry;
  logic chan_sel;
  logic bad_value;
  logic req_err;
  logic do_write;

  ofs_chan_if ch0_if ();
  ofs_chan_if ch1_if ();

  ////////////////////////////////////////////////////////////////////////////
  // Index lookup; unknown indices map to no object
  function automatic ofs_pkg::ofs_obj_t idx_to_obj(input logic [15:0] idx);
    ofs_pkg::ofs_obj_t o;
    unique case (idx)
      ofs_pkg::IDX_SW_RESPONSE: o = ofs_pkg::OBJ_SW_RESPONSE;
      ofs_pkg::IDX_SW_LEVEL: o = ofs_pkg::OBJ_SW_LEVEL;
      ofs_pkg::IDX_CI_DIGITS: o = ofs_pkg::OBJ_CI_DIGITS;
      ofs_pkg::IDX_KIND: o = ofs_pkg::OBJ_KIND;
      ofs_pkg::IDX_DO_DIGITS: o = ofs_pkg::OBJ_DO_DIGITS;
      ofs_pkg::IDX_AN_RESPONSE: o = ofs_pkg::OBJ_AN_RESPONSE;
      ofs_pkg::IDX_CI_VALUE: o = ofs_pkg::OBJ_CI_VALUE;
      ofs_pkg::IDX_LOWER_POINT: o = ofs_pkg::OBJ_LOWER_POINT;
      ofs_pkg::IDX_AN_LEVEL: o = ofs_pkg::OBJ_AN_LEVEL;
      default: o = ofs_pkg::OBJ_NONE;
    endcase
    return o;
  endfunction

  // Read value of one object of one channel, zero-extended
  function automatic logic [15:0] read_field(input ofs_pkg::ofs_chan_state_t c,
                                             input ofs_pkg::ofs_obj_t o);
    logic [15:0] v;
    unique case (o)
      ofs_pkg::OBJ_NONE: v = 16'h0000;
      ofs_pkg::OBJ_SW_RESPONSE: v = {8'h00, c.switched_fault_response};
      ofs_pkg::OBJ_SW_LEVEL: v = {15'h0000, c.switched_fault_level};
      ofs_pkg::OBJ_CI_DIGITS: v = {8'h00, c.control_input_digits};
      ofs_pkg::OBJ_KIND: v = c.analog_channel_kind;
      ofs_pkg::OBJ_DO_DIGITS: v = {8'h00, c.drive_output_digits};
      ofs_pkg::OBJ_AN_RESPONSE: v = {8'h00, c.analog_fault_response};
      ofs_pkg::OBJ_CI_VALUE: v = c.control_input_value;
      ofs_pkg::OBJ_LOWER_POINT: v = c.lower_input_point;
      ofs_pkg::OBJ_AN_LEVEL: v = c.analog_fault_level;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Request decode
  assign hit_obj = idx_to_obj(obj_index);
  assign sub_count = (obj_subindex == ofs_pkg::SUB_COUNT);
  assign sub_entry = (obj_subindex == ofs_pkg::SUB_FIRST) ||
                     (obj_subindex == ofs_pkg::SUB_LAST);
  assign chan_sel = (obj_subindex == ofs_pkg::SUB_LAST);

  // Digit counts and the boolean level are range checked before storing
  assign bad_value = ((hit_obj == ofs_pkg::OBJ_CI_DIGITS ||
                       hit_obj == ofs_pkg::OBJ_DO_DIGITS) &&
                      (obj_wdata > ofs_pkg::DIGITS_MAX)) ||
                     ((hit_obj == ofs_pkg::OBJ_SW_LEVEL) &&
                      (obj_wdata > ofs_pkg::LEVEL_MAX));

  // Sub-index zero is read-only; unknown objects and sub-indices are refused
  assign req_err = (hit_obj == ofs_pkg::OBJ_NONE) ||
                   !(sub_count || sub_entry) ||
                   (obj_wr && sub_count) ||
                   (obj_wr && bad_value);
  assign do_write = obj_req && obj_wr && !req_err;

  ////////////////////////////////////////////////////////////////////////////
  // Write strobes to the two channel stores
  assign ch0_if.wr_en = do_write && !chan_sel;
  assign ch0_if.wr_obj = hit_obj;
  assign ch0_if.wr_data = obj_wdata;
  assign ch1_if.wr_en = do_write && chan_sel;
  assign ch1_if.wr_obj = hit_obj;
  assign ch1_if.wr_data = obj_wdata;
  assign cfg[0] = ch0_if.cfg;
  assign cfg[1] = ch1_if.cfg;

  ofs_channel u_chan0 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .port_if(ch0_if.store)
  );

  ofs_channel u_chan1 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .port_if(ch1_if.store)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Answer and output paths; outputs registered so the pins never glitch
  always_comb begin
    state_next = state_reg;
    state_next.obj_ack = obj_req;
    if (obj_req) begin
      state_next.obj_err = req_err;
      if (req_err || obj_wr) begin
        state_next.obj_rdata = 16'h0000;
      end else if (sub_count) begin
        state_next.obj_rdata = ofs_pkg::SUB_MAX_VALUE;
      end else begin
        state_next.obj_rdata = read_field(cfg[chan_sel], hit_obj);
      end
    end
    for (int i = 0; i < 2; i++) begin
      // Only the apply-level response overrides; other codes leave the path alone
      if (switched_fault_in[i] &&
          cfg[i].switched_fault_response == ofs_pkg::RESPONSE_APPLY) begin
        state_next.switched_out[i] = cfg[i].switched_fault_level;
      end else begin
        state_next.switched_out[i] = switched_cmd[i];
      end
      if (analog_fault_in[i] &&
          cfg[i].analog_fault_response == ofs_pkg::RESPONSE_APPLY) begin
        state_next.analog_drive[i] = cfg[i].analog_fault_level;
      end else begin
        state_next.analog_drive[i] = analog_scaled_value[i];
      end
      // Message-controlled channels take the stored control input value
      if (analog_src_msg[i]) begin
        state_next.analog_fb_input[i] = cfg[i].control_input_value;
      end else begin
        state_next.analog_fb_input[i] = analog_local_input[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ofs_pkg::BANK_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the bank and channel registers
  assign obj_ack = state_reg.obj_ack;
  assign obj_err = state_reg.obj_err;
  assign obj_rdata = state_reg.obj_rdata;
  assign switched_out = state_reg.switched_out;
  assign analog_drive = state_reg.analog_drive;
  assign analog_fb_input = state_reg.analog_fb_input;

  // Lower point stays in control input digits even for locally driven channels
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      control_input_digits[i] = cfg[i].control_input_digits;
      drive_output_digits[i] = cfg[i].drive_output_digits;
      analog_channel_kind[i] = cfg[i].analog_channel_kind;
      lower_input_point[i] = cfg[i].lower_input_point;
    end
  end

endmodule // ofs_object_bank
`default_nettype wire

//--- tb/ofs_bank_assertions.sv
// Port-level checks of the object bank
`timescale 1ns/100ps
`default_nettype none
module ofs_bank_assertions (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic obj_req,
  input wire logic obj_wr,
  input wire logic [15:0] obj_index,
  input wire logic [7:0] obj_subindex,
  input wire logic [15:0] obj_wdata,
  input wire logic obj_ack,
  input wire logic obj_err,
  input wire logic [15:0] obj_rdata,
  input wire logic [1:0] analog_fault_in,
  input wire logic [1:0][15:0] analog_scaled_value,
  input wire logic [1:0][15:0] analog_drive,
  input wire logic [1:0][7:0] control_input_digits,
  input wire logic [1:0][7:0] drive_output_digits,
  input wire logic [1:0][15:0] analog_channel_kind,
  input wire logic [1:0][15:0] lower_input_point
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Steps of one access: the taken request, then a write with its data condition
  sequence s_take;
    obj_req;
  endsequence
  sequence s_wr(logic [15:0] ix, logic [7:0] sub, logic ok);
    obj_req && obj_wr && obj_index == ix && obj_subindex == sub && ok;
  endsequence
  property p_ack_once;
    s_take |=> obj_ack;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("no answer after request");
  property p_ack_cause;
    obj_ack |-> $past(obj_req);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
  property p_write_quiet;
    s_take ##0 obj_wr |=> obj_rdata == 16'h0000;
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("write answer not zero");
  property p_count;
    s_take ##0 (!obj_wr && obj_subindex == 8'h00 && obj_index == ofs_pkg::IDX_KIND)
      |=> obj_rdata == ofs_pkg::SUB_MAX_VALUE && !obj_err;
  endproperty
  a_count: assert property (p_count) else $error("count entry wrong");
  property p_count_ro;
    s_wr(ofs_pkg::IDX_SW_LEVEL, 8'h00, 1'b1) |=> obj_err;
  endproperty
  a_count_ro: assert property (p_count_ro) else $error("count entry written");
  // The whole word is range checked, so upper data bits count too
  property p_digit_refuse;
    s_wr(ofs_pkg::IDX_CI_DIGITS, 8'h01, obj_wdata > ofs_pkg::DIGITS_MAX)
      |=> obj_err && control_input_digits[0] == $past(control_input_digits[0]);
  endproperty
  a_digit_refuse: assert property (p_digit_refuse) else $error("digit refusal failed");
  property p_digit_write;
    s_wr(ofs_pkg::IDX_CI_DIGITS, 8'h01, obj_wdata <= ofs_pkg::DIGITS_MAX)
      |=> !obj_err && control_input_digits[0] == $past(obj_wdata[7:0]);
  endproperty
  a_digit_write: assert property (p_digit_write) else $error("input digits not stored");
  property p_fv_digit;
    s_wr(ofs_pkg::IDX_DO_DIGITS, 8'h02, obj_wdata <= ofs_pkg::DIGITS_MAX)
      |=> drive_output_digits[1] == $past(obj_wdata[7:0]);
  endproperty
  a_fv_digit: assert property (p_fv_digit) else $error("output digits not stored");
  property p_lower;
    s_wr(ofs_pkg::IDX_LOWER_POINT, 8'h01, 1'b1) |=> lower_input_point[0] == $past(obj_wdata);
  endproperty
  a_lower: assert property (p_lower) else $error("lower point not stored");
  // Input digits, kind and lower point show reset values at the first edge after release
  property p_reset;
    $rose(rst_n) |-> control_input_digits == {2{ofs_pkg::RST_DIGITS}}
      && analog_channel_kind == {2{ofs_pkg::RST_KIND}} && lower_input_point == 32'h0000_0000;
  endproperty
  a_reset: assert property (p_reset) else $error("config reset values wrong");
  property p_drive_normal;
    !analog_fault_in[1] |=> analog_drive[1] == $past(analog_scaled_value[1]);
  endproperty
  a_drive_normal: assert property (p_drive_normal) else $error("drive not normal value");
endmodule // ofs_bank_assertions
bind ofs_object_bank ofs_bank_assertions i_chk (.*);
`default_nettype wire

//--- tb/ofs_master_model.sv
// Network master model issuing object accesses
`timescale 1ns/100ps
`default_nettype none
module ofs_master_model (
  input wire logic clk_sys,
  output logic obj_req,
  output logic obj_wr,
  output logic [15:0] obj_index,
  output logic [7:0] obj_subindex,
  output logic [15:0] obj_wdata,
  input wire logic obj_ack,
  input wire logic obj_err,
  input wire logic [15:0] obj_rdata
);
  initial begin
    {obj_req, obj_wr, obj_index, obj_subindex, obj_wdata} = '0;
  end
  // Called at a falling edge; answer taken one cycle later, request may follow at once
  task automatic access(input logic wr, input logic [15:0] ix, input logic [7:0] sub,
    input logic [15:0] wd, output logic ack, output logic err, output logic [15:0] rd);
    obj_req = 1'b1;
    obj_wr = wr;
    obj_index = ix;
    obj_subindex = sub;
    obj_wdata = wd;
    @(negedge clk_sys);
    ack = obj_ack;
    err = obj_err;
    rd = obj_rdata;
  endtask
  // Idle lines flip so a stale request value is never mistaken for live data
  task automatic release_bus;
    obj_req = 1'b0;
    {obj_wr, obj_index, obj_subindex, obj_wdata} = ~{obj_wr, obj_index, obj_subindex, obj_wdata};
  endtask
endmodule // ofs_master_model
`default_nettype wire

//--- tb/ofs_object_bank_tb.sv
// Self-checking bench of the object bank
`timescale 1ns/100ps
`default_nettype none
module ofs_object_bank_tb;
  logic clk_sys, rst_n, obj_req, obj_wr, obj_ack, obj_err, ack, err;
  logic [15:0] obj_index, obj_wdata, obj_rdata, rd, v;
  logic [7:0] obj_subindex;
  logic [1:0] switched_cmd, switched_fault_in, switched_out, analog_src_msg, analog_fault_in;
  logic [1:0][15:0] analog_local_input, analog_scaled_value, analog_fb_input, analog_drive;
  logic [1:0][15:0] analog_channel_kind, lower_input_point;
  logic [1:0][7:0] control_input_digits, drive_output_digits;
  logic [15:0] idx_tab [10];
  logic [15:0] shd [10][2];
  int err_count, comparisons, k, s;
  ofs_object_bank i_dut (.*);
  ofs_master_model i_master (.*);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  function automatic logic [15:0] rst_val(int n);
    case (n)
      0, 1, 5: return 16'h0001;
      2, 4: return 16'h0003;
      3: return 16'h000A;
      default: return 16'h0000;
    endcase
  endfunction
  function automatic logic [15:0] msk(int n);
    return (n == 1) ? 16'h0001 : (n == 0 || n == 2 || n == 4 || n == 5) ? 16'h00FF : 16'hFFFF;
  endfunction
  function automatic logic legal(int n, logic [15:0] d);
    return !((n == 2 || n == 4) && d > 16'h0004) && !(n == 1 && d > 16'h0001);
  endfunction
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // One access with answer expected from the shadow copy; slot 9 is an unmapped index
  task automatic xfer(logic wr, int n, logic [7:0] sub, logic [15:0] wd);
    logic bad;
    logic [15:0] e;
    bad = (n == 9) || sub > 8'h02 || (wr && (sub == 8'h00 || !legal(n, wd)));
    e = (wr || bad) ? 16'h0000 : (sub == 8'h00) ? 16'h0002 : shd[n][sub - 8'h01];
    if (wr && !bad) shd[n][sub - 8'h01] = wd & msk(n);
    i_master.access(wr, idx_tab[n], sub, wd, ack, err, rd);
    chk("obj_ack", 16'h0001, {15'h0, ack});
    chk("obj_err", {15'h0, bad}, {15'h0, err});
    chk("obj_rdata", e, rd);
  endtask
  task automatic chk_cfg;
    for (int c = 0; c < 2; c++) begin
      chk("ci_digits", shd[2][c], {8'h00, control_input_digits[c]});
      chk("fv_digits", shd[4][c], {8'h00, drive_output_digits[c]});
      chk("kind", shd[3][c], analog_channel_kind[c]);
      chk("lower_point", shd[7][c], lower_input_point[c]);
    end
  endtask
  // Random path inputs, result one cycle later
  task automatic paths;
    @(negedge clk_sys);
    {switched_cmd, switched_fault_in, analog_src_msg, analog_fault_in} = 8'($urandom);
    analog_local_input = {16'($urandom), 16'($urandom)};
    analog_scaled_value = {16'($urandom), 16'($urandom)};
    @(negedge clk_sys);
    for (int c = 0; c < 2; c++) begin
      v = (switched_fault_in[c] && shd[0][c] == 16'h0001) ? shd[1][c] : switched_cmd[c];
      chk("switched_out", v, {15'h0, switched_out[c]});
      v = (analog_fault_in[c] && shd[5][c] == 16'h0001) ? shd[8][c] : analog_scaled_value[c];
      chk("analog_drive", v, analog_drive[c]);
      v = analog_src_msg[c] ? shd[6][c] : analog_local_input[c];
      chk("fb_input", v, analog_fb_input[c]);
    end
  endtask
  task automatic close_out;
    if (err_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run of about 450 cycles
  initial begin
    #(25 * 20000);
    err_count++;
    close_out();
  end
  initial begin
    void'($urandom(46776));
    rst_n = 1'b0;
    {switched_cmd, switched_fault_in, analog_src_msg, analog_fault_in} = 8'h00;
    analog_local_input = '0;
    analog_scaled_value = '0;
    idx_tab = '{ofs_pkg::IDX_SW_RESPONSE, ofs_pkg::IDX_SW_LEVEL, ofs_pkg::IDX_CI_DIGITS,
      ofs_pkg::IDX_KIND, ofs_pkg::IDX_DO_DIGITS, ofs_pkg::IDX_AN_RESPONSE,
      ofs_pkg::IDX_CI_VALUE, ofs_pkg::IDX_LOWER_POINT, ofs_pkg::IDX_AN_LEVEL, 16'h7321};
    for (int n = 0; n < 10; n++) for (int c = 0; c < 2; c++) shd[n][c] = rst_val(n);
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    // Reset values and count entries of every object
    for (int n = 0; n < 9; n++) for (int b = 0; b < 3; b++) xfer(1'b0, n, 8'(b), 16'h0000);
    chk_cfg();
    // Random legal writes, each read back at once
    repeat (60) begin
      k = $urandom_range(8);
      s = $urandom_range(2, 1);
      v = 16'($urandom) & msk(k);
      if (k == 2 || k == 4) v = 16'($urandom_range(4));
      if (k == 7) v = 16'($urandom_range(4999));
      xfer(1'b1, k, 8'(s), v);
      xfer(1'b0, k, 8'(s), 16'h0000);
    end
    chk_cfg();
    // Boundary and refused writes, unmapped places
    xfer(1'b1, 2, 8'h02, 16'h0004);
    xfer(1'b1, 2, 8'h01, 16'h0005);
    xfer(1'b1, 4, 8'h02, 16'h00FF);
    xfer(1'b1, 1, 8'h01, 16'h0002);
    xfer(1'b1, 3, 8'h00, 16'h0001);
    xfer(1'b1, 1, 8'h00, 16'h0001);
    xfer(1'b0, 6, 8'h03, 16'h0000);
    xfer(1'b1, 9, 8'h01, 16'h0001);
    i_master.release_bus();
    chk_cfg();
    // Fault handling with response modes 0, 1 and 2
    repeat (40) begin
      s = $urandom_range(2, 1);
      xfer(1'b1, 0, 8'(s), 16'($urandom_range(2)));
      xfer(1'b1, 5, 8'(s), 16'($urandom_range(2)));
      xfer(1'b1, 1, 8'(s), 16'($urandom_range(1)));
      xfer(1'b1, 8, 8'(s), 16'($urandom));
      xfer(1'b1, 6, 8'(s), 16'($urandom));
      i_master.release_bus();
      paths();
    end
    close_out();
  end
endmodule // ofs_object_bank_tb
`default_nettype wire
